//--- lpcc_bus_master.sv
// external bus master beside the power-mode clock control
// assumes go is a one-cycle pulse from the bench
`timescale 1ns/1ps
`default_nettype none
module lpcc_bus_master #(
    parameter int HOLD = 4
) (
    // clock and reset
    input  wire logic       clk,
    input  wire logic       arst_n,
    // bench command and bus handshake
    input  wire logic       go,
    input  wire logic       bus_grant,
    output logic            external_bus_request,
    output logic [7:0]      held
);
    // request held until granted HOLD cycles
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            external_bus_request <= 1'b0;
            held                 <= 8'h00;
        end else if (external_bus_request) begin
            held                 <= held + {7'h00, bus_grant};
            external_bus_request <= !(bus_grant && held == 8'(HOLD - 1));
        end else if (go) begin
            external_bus_request <= 1'b1;
            held                 <= 8'h00;
        end
    end
endmodule
`default_nettype wire

//--- lpcc_clk_div.sv
// master clock divider: crystal halved or undivided, one tick per master cycle
// assumes clk is the crystal rate and clk_en freezes it with the rest of the block
`timescale 1ns/1ps
`default_nettype none
module lpcc_clk_div (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic clk_en,
    // control
    input  wire logic div_one,
    input  wire logic osc_run,
    input  wire logic out_en,
    // master clock
    output logic      tick,
    output logic      clk_out
);
    logic phase_reg;
    logic phase_next;
    logic tick_reg;
    logic tick_next;
    logic out_reg;
    logic out_next;

    // a stopped oscillator gives no ticks at all; clock pin blocked separately
    always_comb begin
        phase_next = phase_reg;
        tick_next  = 1'b0;
        out_next   = out_reg;
        if (osc_run) begin
            phase_next = ~phase_reg;
            tick_next  = div_one | phase_reg;
        end
        if (tick_next && out_en) begin
            out_next = ~out_reg;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            phase_reg <= 1'b0;
            tick_reg  <= 1'b0;
            out_reg   <= 1'b0;
        end else if (clk_en) begin
            phase_reg <= phase_next;
            tick_reg  <= tick_next;
            out_reg   <= out_next;
        end
    end

    assign tick    = tick_reg;
    assign clk_out = out_reg;
endmodule
`default_nettype wire

//--- lpcc_params.svh
// offsets, field positions, reset values and timing counts of the power-mode clock control
// assumes an 8-bit register port and a crystal-rate clk into the top module
`ifndef LPCC_PARAMS_SVH
`define LPCC_PARAMS_SVH

`define LPCC_CCR_OFS      8'h1f
`define LPCC_IOCTL_OFS    8'h20
`define LPCC_STATUS_OFS   8'h21

`define LPCC_CCR_DIV_BIT  7
`define LPCC_CCR_STBY_BIT 6
`define LPCC_CCR_STANDBY_BUS_GRANT_ENABLE_BIT 5
`define LPCC_CCR_IDLE_BIT 3
`define LPCC_IO_STOP_BIT_BIT   5

`define LPCC_CCR_RST      8'h00
`define LPCC_IOCTL_RST    8'h00

`define LPCC_STANDBY_WAIT 131072
`define LPCC_QUICK_WAIT   64

`endif

//--- lpcc_pkg.sv
// types shared by the power-mode clock control modules
// assumes nothing beyond a SystemVerilog compiler
package lpcc_pkg;

    // gray codes along run, halt, sleep, stop, idle, standby, warm-up, bus hold
    typedef enum logic [2:0] {
        LPCC_RUN     = 3'h0,
        LPCC_HALT    = 3'h1,
        LPCC_SLEEP   = 3'h3,
        LPCC_SYSSTOP = 3'h2,
        LPCC_IDLE    = 3'h6,
        LPCC_STANDBY = 3'h7,
        LPCC_WARMUP  = 3'h5,
        LPCC_BUSHOLD = 3'h4
    } lpcc_state_type;

    // clock and activity enables handed to the rest of the chip
    typedef struct packed {
        logic core;
        logic dma;
        logic io;
        logic refresh;
        logic osc;
    } lpcc_gate_type;

    // what happens on leaving a power-down mode
    typedef struct packed {
        logic       take_int;
        logic [3:0] int_id;
    } lpcc_wake_type;

endpackage

//--- lpcc_properties.sv
// concurrent checks on the ports of the power-mode clock control
// assumes it is bound into lpcc_top and that clk_en stays high
`timescale 1ns/1ps
`default_nettype none
module lpcc_properties #(
    parameter int ADDR_W   = 20,
    parameter int ONCHIP_N = 8
) (
    // clock, reset and register writes
    input wire logic                     clk,
    input wire logic                     arst_n,
    input wire logic [7:0]               reg_addr,
    input wire logic [7:0]               reg_wdata,
    input wire logic                     reg_wr,
    // core events, interrupt sources and the external bus request
    input wire logic                     halt_instruction,
    input wire logic                     sleep_instruction,
    input wire logic [ADDR_W-1:0]        next_instr_addr,
    input wire logic                     nmi_req,
    input wire logic [2:0]               maskable_req,
    input wire logic [2:0]               maskable_en,
    input wire logic [ONCHIP_N-1:0]      onchip_req,
    input wire logic [ONCHIP_N-1:0]      onchip_en,
    input wire logic                     global_interrupt_enable_flag,
    input wire logic                     external_bus_request,
    // block outputs
    input wire logic                     bus_grant,
    input wire lpcc_pkg::lpcc_gate_type  clk_gates,
    input wire logic                     master_tick,
    input wire logic [ADDR_W-1:0]        addr_out,
    input wire logic                     addr_oe_n,
    input wire logic                     ctrl_force_high,
    input wire logic                     halt_n,
    input wire logic                     wake_pulse,
    input wire lpcc_pkg::lpcc_wake_type  wake,
    input wire logic [ADDR_W-1:0]        resume_addr,
    input wire lpcc_pkg::lpcc_state_type mode
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    logic div_reg;
    logic div_next;
    logic src_on;
    // the non-maskable request, or any other wake source that is individually enabled
    assign src_on = nmi_req || |(maskable_req & maskable_en) || |(onchip_req & onchip_en);
    // shadow of the divide select, so tick spacing can be judged without internals
    always_comb begin
        div_next = (reg_wr && reg_addr == 8'h1f) ? reg_wdata[7] : div_reg;
    end
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n)
            div_reg <= 1'b0;
        else
            div_reg <= div_next;
    end
    chk_sleep_gates: assert property (
        mode == lpcc_pkg::LPCC_SLEEP |-> clk_gates == 5'h05) else $error("sleep gates wrong");
    chk_sleep_pins: assert property (
        mode == lpcc_pkg::LPCC_SLEEP && !bus_grant |-> !addr_oe_n && &addr_out
        && ctrl_force_high && !halt_n) else $error("sleep pin override wrong");
    chk_sleep_grant: assert property (
        mode == lpcc_pkg::LPCC_SLEEP && external_bus_request |=> bus_grant && addr_oe_n
        && !ctrl_force_high) else $error("no grant while asleep");
    chk_masked_stay: assert property (
        mode == lpcc_pkg::LPCC_SLEEP && !src_on |=> mode == lpcc_pkg::LPCC_SLEEP)
        else $error("left sleep without enabled source");
    chk_wake_run: assert property (
        mode inside {lpcc_pkg::LPCC_HALT, lpcc_pkg::LPCC_SLEEP} && src_on
        |=> mode == lpcc_pkg::LPCC_RUN && wake_pulse ##1 !wake_pulse) else $error("wake wrong");
    chk_take_int: assert property (
        mode == lpcc_pkg::LPCC_SLEEP && src_on |=> wake.take_int ==
        ($past(nmi_req) || $past(global_interrupt_enable_flag))) else $error("take_int wrong");
    chk_resume_addr: assert property (
        mode == lpcc_pkg::LPCC_RUN && (sleep_instruction || halt_instruction)
        |=> resume_addr == $past(next_instr_addr)) else $error("resume address wrong");
    chk_tick_half: assert property (
        master_tick && !div_reg && !$past(div_reg) |=> !master_tick)
        else $error("ticks not halved");
endmodule
bind lpcc_top lpcc_properties #(.ADDR_W(ADDR_W), .ONCHIP_N(ONCHIP_N)) u_props (.*);
`default_nettype wire

//--- lpcc_top.sv
// power-down mode sequencer and master clock control of the 8-bit processor
// assumes cpu strobes are one clk long and all inputs are synchronous to clk
//
// Our own choice: the plain strobed port.
`include "lpcc_params.svh"
`timescale 1ns/1ps
`default_nettype none
module lpcc_top #(
    parameter int ADDR_W              = 20,
    parameter int ONCHIP_N            = 8,
    parameter int STANDBY_WAIT_CYCLES = `LPCC_STANDBY_WAIT,
    parameter int QUICK_WAIT_CYCLES   = `LPCC_QUICK_WAIT
) (
    // clock, reset, freeze
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  clk_en,
    // register port
    input  wire logic [7:0]            reg_addr,
    input  wire logic [7:0]            reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [7:0]            reg_rdata,
    // cpu core events
    input  wire logic                  halt_instruction,
    input  wire logic                  sleep_instruction,
    input  wire logic [ADDR_W-1:0]     next_instr_addr,
    // interrupt sources
    input  wire logic                  nmi_req,
    input  wire logic [2:0]            maskable_req,
    input  wire logic [2:0]            maskable_en,
    input  wire logic [ONCHIP_N-1:0]   onchip_req,
    input  wire logic [ONCHIP_N-1:0]   onchip_en,
    input  wire logic                  global_interrupt_enable_flag,
    // external bus master
    input  wire logic                  external_bus_request,
    output logic                       bus_grant,
    // clocks and gates
    output lpcc_pkg::lpcc_gate_type    clk_gates,
    output logic                       master_tick,
    output logic                       master_clock_out,
    // pin overrides while asleep
    output logic      [ADDR_W-1:0]     addr_out,
    output logic                       addr_oe_n,
    output logic                       ctrl_force_high,
    output logic                       halt_n,
    // wake-up report to the core
    output logic                       wake_pulse,
    output lpcc_pkg::lpcc_wake_type    wake,
    output logic      [ADDR_W-1:0]     resume_addr,
    output lpcc_pkg::lpcc_state_type   mode
);
    localparam int CNT_W = $clog2(STANDBY_WAIT_CYCLES + 1);

    // refuse settings the counter or the id field cannot hold
    if (ONCHIP_N < 1 || ONCHIP_N > 12) begin : g_bad_onchip
        $error("ONCHIP_N must be 1 to 12");
    end
    if (QUICK_WAIT_CYCLES < 1 || QUICK_WAIT_CYCLES > STANDBY_WAIT_CYCLES) begin : g_bad_wait
        $error("wait counts must be at least 1 and quick not above standby");
    end

    // highest priority active source: non-maskable, maskable 0..2, on-chip
    function automatic logic [3:0] pick_source(input logic nmi,
                                               input logic [2:0] ext,
                                               input logic [ONCHIP_N-1:0] onc);
        logic [3:0] id;
        id = 4'h0;
        if (!nmi) begin
            if (ext[0]) id = 4'h1;
            else if (ext[1]) id = 4'h2;
            else if (ext[2]) id = 4'h3;
            else begin
                for (int k = ONCHIP_N - 1; k >= 0; k--) begin
                    if (onc[k]) id = 4'(k + 4);
                end
            end
        end
        return id;
    endfunction

    // power-down state chosen by the sleep instruction
    function automatic lpcc_pkg::lpcc_state_type pick_mode(input logic io_stop_bit,
                                                           input logic stby,
                                                           input logic idle);
        lpcc_pkg::lpcc_state_type m;
        m = lpcc_pkg::LPCC_SLEEP;
        if (io_stop_bit) begin
            if (!stby && !idle) m = lpcc_pkg::LPCC_SYSSTOP;
            else if (!stby) m = lpcc_pkg::LPCC_IDLE;
            else m = lpcc_pkg::LPCC_STANDBY;
        end
        return m;
    endfunction

    // state
    lpcc_pkg::lpcc_state_type state_reg, state_next;
    logic [7:0]               ccr_reg, ccr_next;
    logic [7:0]               ioctl_reg, ioctl_next;
    logic [7:0]               rdata_reg, rdata_next;
    logic [CNT_W-1:0]         cnt_reg, cnt_next;
    logic                     for_bus_reg, for_bus_next;
    logic                     pend_reg, pend_next;
    lpcc_pkg::lpcc_wake_type  pend_info_reg, pend_info_next;
    logic                     quick_reg, quick_next;
    logic [ADDR_W-1:0]        resume_reg, resume_next;
    logic                     wake_pulse_reg, wake_pulse_next;
    lpcc_pkg::lpcc_wake_type  wake_reg, wake_next;
    logic                     grant_reg, grant_next;
    lpcc_pkg::lpcc_gate_type  gates_reg, gates_next;
    logic                     clkout_en_reg, clkout_en_next;
    logic                     override_reg, override_next;
    logic                     halt_n_reg, halt_n_next;

    // wake sources and what they lead to
    logic                     wake_src;
    lpcc_pkg::lpcc_wake_type  wake_now;
    logic                     tick;
    logic                     asleep;

    // only individually enabled sources count; non-maskable always does
    assign wake_src = nmi_req | (|(maskable_req & maskable_en))
                    | (|(onchip_req & onchip_en));
    assign wake_now.take_int = nmi_req | global_interrupt_enable_flag;
    assign wake_now.int_id = pick_source(nmi_req, maskable_req & maskable_en,
                                         onchip_req & onchip_en);

    // register file and read data, one cycle after the read strobe only
    always_comb begin
        ccr_next   = ccr_reg;
        ioctl_next = ioctl_reg;
        rdata_next = 8'h00;
        if (reg_wr) begin
            if (reg_addr == `LPCC_CCR_OFS) ccr_next = reg_wdata;
            if (reg_addr == `LPCC_IOCTL_OFS) ioctl_next = reg_wdata;
        end
        if (reg_rd) begin
            case (reg_addr)
                `LPCC_CCR_OFS:    rdata_next = ccr_reg;
                `LPCC_IOCTL_OFS:  rdata_next = ioctl_reg;
                `LPCC_STATUS_OFS: rdata_next = {state_reg, gates_reg.osc, grant_reg,
                                                pend_reg, quick_reg, for_bus_reg};
                default:          rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ccr_reg   <= `LPCC_CCR_RST;
            ioctl_reg <= `LPCC_IOCTL_RST;
            rdata_reg <= 8'h00;
        end else if (clk_en) begin
            ccr_reg   <= ccr_next;
            ioctl_reg <= ioctl_next;
            rdata_reg <= rdata_next;
        end
    end

    // mode sequencer, wake reporting and stabilisation timer
    always_comb begin
        state_next      = state_reg;
        cnt_next        = cnt_reg;
        for_bus_next    = for_bus_reg;
        pend_next       = pend_reg;
        pend_info_next  = pend_info_reg;
        quick_next      = quick_reg;
        resume_next     = resume_reg;
        wake_pulse_next = 1'b0;
        wake_next       = wake_reg;
        case (state_reg)
            lpcc_pkg::LPCC_RUN: begin
                if (sleep_instruction) begin
                    resume_next = next_instr_addr;
                    quick_next  = ccr_reg[`LPCC_CCR_IDLE_BIT];
                    state_next  = pick_mode(ioctl_reg[`LPCC_IO_STOP_BIT_BIT],
                                            ccr_reg[`LPCC_CCR_STBY_BIT],
                                            ccr_reg[`LPCC_CCR_IDLE_BIT]);
                end else if (halt_instruction) begin
                    resume_next = next_instr_addr;
                    state_next  = lpcc_pkg::LPCC_HALT;
                end
            end
            lpcc_pkg::LPCC_HALT,
            lpcc_pkg::LPCC_SLEEP,
            lpcc_pkg::LPCC_SYSSTOP,
            lpcc_pkg::LPCC_IDLE: begin
                if (wake_src) begin
                    wake_pulse_next = 1'b1;
                    wake_next       = wake_now;
                    state_next      = lpcc_pkg::LPCC_RUN;
                end
            end
            lpcc_pkg::LPCC_STANDBY: begin
                // restart oscillator and wait before anything runs
                cnt_next = quick_reg ? CNT_W'(QUICK_WAIT_CYCLES - 1)
                                     : CNT_W'(STANDBY_WAIT_CYCLES - 1);
                if (wake_src) begin
                    pend_next      = 1'b1;
                    pend_info_next = wake_now;
                    for_bus_next   = 1'b0;
                    state_next     = lpcc_pkg::LPCC_WARMUP;
                end else if (external_bus_request && ccr_reg[`LPCC_CCR_STANDBY_BUS_GRANT_ENABLE_BIT]) begin
                    for_bus_next = 1'b1;
                    state_next   = lpcc_pkg::LPCC_WARMUP;
                end
            end
            lpcc_pkg::LPCC_WARMUP: begin
                if (wake_src && !pend_reg) begin
                    pend_next      = 1'b1;
                    pend_info_next = wake_now;
                end
                if (tick) begin
                    if (cnt_reg == '0) begin
                        if (for_bus_reg && external_bus_request) begin
                            state_next = lpcc_pkg::LPCC_BUSHOLD;
                        end else if (pend_reg) begin
                            wake_pulse_next = 1'b1;
                            wake_next       = pend_info_reg;
                            pend_next       = 1'b0;
                            state_next      = lpcc_pkg::LPCC_RUN;
                        end else begin
                            state_next = lpcc_pkg::LPCC_STANDBY;
                        end
                        for_bus_next = 1'b0;
                    end else begin
                        cnt_next = cnt_reg - 1'b1;
                    end
                end
            end
            lpcc_pkg::LPCC_BUSHOLD: begin
                if (wake_src && !pend_reg) begin
                    pend_next      = 1'b1;
                    pend_info_next = wake_now;
                end
                // oscillator stays warm, so a wake pending at release needs no wait
                if (!external_bus_request) begin
                    if (pend_next) begin
                        wake_pulse_next = 1'b1;
                        wake_next       = pend_next == pend_reg ? pend_info_reg : wake_now;
                        pend_next       = 1'b0;
                        state_next      = lpcc_pkg::LPCC_RUN;
                    end else begin
                        state_next = lpcc_pkg::LPCC_STANDBY;
                    end
                end
            end
            default: begin
                state_next = lpcc_pkg::LPCC_RUN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_reg      <= lpcc_pkg::LPCC_RUN;
            cnt_reg        <= '0;
            for_bus_reg    <= 1'b0;
            pend_reg       <= 1'b0;
            pend_info_reg  <= '0;
            quick_reg      <= 1'b0;
            resume_reg     <= '0;
            wake_pulse_reg <= 1'b0;
            wake_reg       <= '0;
        end else if (clk_en) begin
            state_reg      <= state_next;
            cnt_reg        <= cnt_next;
            for_bus_reg    <= for_bus_next;
            pend_reg       <= pend_next;
            pend_info_reg  <= pend_info_next;
            quick_reg      <= quick_next;
            resume_reg     <= resume_next;
            wake_pulse_reg <= wake_pulse_next;
            wake_reg       <= wake_next;
        end
    end

    // gates, bus grant and pin overrides follow the next state, so they
    // change in the same cycle as the mode output
    assign asleep = state_next inside {lpcc_pkg::LPCC_SLEEP, lpcc_pkg::LPCC_SYSSTOP,
                                       lpcc_pkg::LPCC_IDLE, lpcc_pkg::LPCC_STANDBY,
                                       lpcc_pkg::LPCC_WARMUP};

    always_comb begin
        gates_next.core    = state_next inside {lpcc_pkg::LPCC_RUN, lpcc_pkg::LPCC_HALT};
        gates_next.dma     = gates_next.core;
        gates_next.refresh = gates_next.core;
        gates_next.io      = state_next inside {lpcc_pkg::LPCC_RUN, lpcc_pkg::LPCC_HALT,
                                                lpcc_pkg::LPCC_SLEEP};
        gates_next.osc     = state_next != lpcc_pkg::LPCC_STANDBY;
        clkout_en_next     = !(state_next inside {lpcc_pkg::LPCC_IDLE,
                                                  lpcc_pkg::LPCC_STANDBY,
                                                  lpcc_pkg::LPCC_WARMUP});
        // standby grants only from the warm bus-hold state
        grant_next         = external_bus_request && (state_next inside {
                                 lpcc_pkg::LPCC_RUN, lpcc_pkg::LPCC_HALT,
                                 lpcc_pkg::LPCC_SLEEP, lpcc_pkg::LPCC_SYSSTOP,
                                 lpcc_pkg::LPCC_BUSHOLD});
        override_next      = asleep && !grant_next;
        halt_n_next        = !(asleep || state_next == lpcc_pkg::LPCC_HALT);
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            gates_reg     <= 5'h1f;
            clkout_en_reg <= 1'b1;
            grant_reg     <= 1'b0;
            override_reg  <= 1'b0;
            halt_n_reg    <= 1'b1;
        end else if (clk_en) begin
            gates_reg     <= gates_next;
            clkout_en_reg <= clkout_en_next;
            grant_reg     <= grant_next;
            override_reg  <= override_next;
            halt_n_reg    <= halt_n_next;
        end
    end

    // master clock from the crystal, halved unless control bit 7 is set
    lpcc_clk_div u_div (
        .clk     (clk),
        .arst_n  (arst_n),
        .clk_en  (clk_en),
        .div_one (ccr_reg[`LPCC_CCR_DIV_BIT]),
        .osc_run (gates_reg.osc),
        .out_en  (clkout_en_reg),
        .tick    (tick),
        .clk_out (master_clock_out)
    );

    // outputs, all straight from flip-flops
    assign reg_rdata       = rdata_reg;
    assign bus_grant       = grant_reg;
    assign clk_gates       = gates_reg;
    assign master_tick     = tick;
    assign addr_out        = {ADDR_W{override_reg}};
    assign addr_oe_n       = ~override_reg;
    assign ctrl_force_high = override_reg;
    assign halt_n          = halt_n_reg;
    assign wake_pulse      = wake_pulse_reg;
    assign wake            = wake_reg;
    assign resume_addr     = resume_reg;
    assign mode            = state_reg;
endmodule
`default_nettype wire

//--- testbench.sv
// self-checking bench for the power-mode clock control
// assumes short standby waits of 40 and 8 master ticks
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [7:0] MCCR [4] = '{8'h00, 8'h08, 8'h40, 8'h48};
    localparam int LO [4] = '{1, 1, 79, 15};
    localparam int HI [4] = '{1, 1, 88, 24};
    logic clk = 1'b0, arst_n = 1'b0, clk_en = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, bm_go = 1'b0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, onchip_req = 8'h00, onchip_en = 8'h00;
    logic halt_instruction = 1'b0, sleep_instruction = 1'b0, nmi_req = 1'b0;
    logic [19:0] next_instr_addr = 20'h00000;
    logic [2:0] maskable_req = 3'h0, maskable_en = 3'h0;
    logic global_interrupt_enable_flag = 1'b0;
    logic [7:0] reg_rdata, bm_held;
    logic [19:0] addr_out, resume_addr;
    logic external_bus_request, bus_grant, master_tick, master_clock_out;
    logic addr_oe_n, ctrl_force_high, halt_n, wake_pulse;
    lpcc_pkg::lpcc_gate_type clk_gates;
    lpcc_pkg::lpcc_wake_type wake;
    lpcc_pkg::lpcc_state_type mode;
    int fail_count = 0;
    int samples_checked = 0;
    lpcc_top #(.STANDBY_WAIT_CYCLES(40), .QUICK_WAIT_CYCLES(8)) u_dut (.*);
    lpcc_bus_master #(.HOLD(4)) u_bm (.clk(clk), .arst_n(arst_n), .go(bm_go),
        .bus_grant(bus_grant), .external_bus_request(external_bus_request), .held(bm_held));
    // free-running clock, 4 ns
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report;
        $display("comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask
    task automatic rd_check(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        check(reg_rdata, exp);
    endtask
    // one core event; is_halt picks halt over sleep
    task automatic pulse(input logic is_halt, input logic [19:0] a);
        @(posedge clk);
        halt_instruction  <= is_halt;
        sleep_instruction <= !is_halt;
        next_instr_addr   <= a;
        @(posedge clk);
        halt_instruction  <= 1'b0;
        sleep_instruction <= 1'b0;
        #1;
    endtask
    task automatic wait_wake(output int n);
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (wake_pulse !== 1'b1 && n < 200);
    endtask
    task automatic ticks(input int exp);
        int n;
        n = 0;
        repeat (20) begin
            @(posedge clk);
            #1;
            n += int'(master_tick === 1'b1);
        end
        check(n, exp);
    endtask
    task automatic t_regs;
        rd_check(8'h1f, 8'h00);
        ticks(10);
        wr(8'h1f, 8'h80);
        rd_check(8'h1f, 8'h80);
        ticks(20);
        rd_check(8'h30, 8'h00);
        wr(8'h1f, 8'h00);
    endtask
    // sleep with a disabled source active, a bus loan, then an enabled wake, global off
    task automatic t_sleep;
        int n;
        maskable_en  <= 3'h2;
        maskable_req <= 3'h1;
        pulse(1'b0, 20'h12345);
        check(mode, lpcc_pkg::LPCC_SLEEP);
        check(clk_gates, 5'h05);
        check({addr_out, addr_oe_n, ctrl_force_high, halt_n}, 23'h7ffffa);
        repeat (5) @(posedge clk);
        bm_go <= 1'b1;
        @(posedge clk);
        bm_go <= 1'b0;
        repeat (12) @(posedge clk);
        #1;
        check({bm_held, bus_grant, addr_oe_n, mode}, {8'h04, 2'b00, 3'h3});
        @(posedge clk);
        maskable_req <= 3'h3;
        wait_wake(n);
        check({n, wake, resume_addr}, {32'h1, 5'h02, 20'h12345});
        @(posedge clk);
        maskable_req <= 3'h0;
    endtask
    // halt, then an on-chip source with global enable on
    task automatic t_halt;
        int n;
        global_interrupt_enable_flag <= 1'b1;
        onchip_en <= 8'h04;
        pulse(1'b1, 20'habcde);
        check({mode, halt_n}, {3'h1, 1'b0});
        @(posedge clk);
        onchip_req <= 8'h04;
        wait_wake(n);
        check({n, wake, resume_addr}, {32'h1, 5'h16, 20'habcde});
        @(posedge clk);
        onchip_req <= 8'h00;
    endtask
    // io stop set: system stop, idle, standby and quick standby, each woken by nmi
    task automatic t_modes;
        int n;
        logic v;
        wr(8'h20, 8'h20);
        for (int i = 0; i < 4; i++) begin
            wr(8'h1f, MCCR[i]);
            pulse(1'b0, 20'h00100);
            check(mode, i == 0 ? 3'h2 : (i == 1 ? 3'h6 : 3'h7));
            if (i == 0)
                check(clk_gates.io, 1'b0);
            v = master_clock_out;
            repeat (6) @(posedge clk);
            #1;
            if (i > 0)
                check(master_clock_out, v);
            @(posedge clk);
            nmi_req <= 1'b1;
            wait_wake(n);
            check(n >= LO[i] && n <= HI[i] && wake === 5'h10, 1'b1);
            @(posedge clk);
            nmi_req <= 1'b0;
        end
        wr(8'h20, 8'h00);
        wr(8'h1f, 8'h00);
    endtask
    // hang guard: runs far longer than the whole sequence needs
    initial begin
        repeat (20000) @(posedge clk);
        fail_count++;
        final_report();
    end
    initial begin
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        t_regs();
        t_sleep();
        t_halt();
        t_modes();
        final_report();
    end
endmodule
`default_nettype wire
